// File: design/ppcp_pkg.sv
// =====================================================================
// Shared constants of the passive parallel configuration port
package ppcp_pkg;

  // =====================================================================
  // Clock and counter sizing
  localparam int unsigned CORE_CLK_MHZ = 100;
  localparam int unsigned CNT_W = 20;
  localparam int unsigned DATA_W = 32;

  // =====================================================================
  // Link timing, each figure in its own unit, then in core clock cycles
  localparam int unsigned REQ_TO_LOW_MAX_NS = 600;
  localparam int unsigned REQ_TO_LOW_CYC = REQ_TO_LOW_MAX_NS * CORE_CLK_MHZ / 1000;
  localparam int unsigned REQ_LOW_MIN_US = 2;
  localparam int unsigned REQ_LOW_CYC = REQ_LOW_MIN_US * CORE_CLK_MHZ;
  localparam int unsigned STATUS_LOW_MIN_US = 268;
  localparam int unsigned STATUS_LOW_MIN_CYC = STATUS_LOW_MIN_US * CORE_CLK_MHZ;
  localparam int unsigned STATUS_LOW_MAX_US = 1506;
  localparam int unsigned STATUS_LOW_MAX_CYC = STATUS_LOW_MAX_US * CORE_CLK_MHZ;
  localparam int unsigned REQ_HIGH_TO_CLK_US = 1506;
  localparam int unsigned REQ_HIGH_TO_CLK_CYC = REQ_HIGH_TO_CLK_US * CORE_CLK_MHZ;
  localparam int unsigned STATUS_TO_CLK_US = 2;
  localparam int unsigned STATUS_TO_CLK_CYC = STATUS_TO_CLK_US * CORE_CLK_MHZ;
  localparam int unsigned INIT_MIN_US = 175;
  localparam int unsigned INIT_MAX_US = 437;
  localparam int unsigned INIT_CYC = INIT_MIN_US * CORE_CLK_MHZ;
  localparam int unsigned POR_DELAY_US = 100;
  localparam int unsigned POR_DELAY_CYC = POR_DELAY_US * CORE_CLK_MHZ;
  localparam int unsigned BIT_CLK_MIN_PERIOD_NS = 8;
  localparam int unsigned STARTUP_WAIT_PERIODS = 4;
  localparam int unsigned STARTUP_WAIT_CYC =
    (STARTUP_WAIT_PERIODS * BIT_CLK_MIN_PERIOD_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned USER_INIT_CLKS = 8576;
  localparam int unsigned TAIL_FALLS = 2;
  localparam int unsigned HALF_PERIOD_CYC = 6;

  // =====================================================================
  // Bus width straps
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // =====================================================================
  // Host register map and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LEN = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam int unsigned CTRL_START_BIT = 0;
  localparam int unsigned CTRL_MONITOR_BIT = 1;
  localparam int unsigned CTRL_RATIO_LSB = 4;
  localparam logic [31:0] CTRL_RST = 32'h00000010;
  localparam logic [31:0] LEN_RST = 32'h00000000;
  localparam int unsigned OPT_STARTUP_DONE_BIT = 0;

  typedef enum logic [2:0] {
    DS_POR = 3'b000,
    DS_HOLD = 3'b001,
    DS_STATUS = 3'b010,
    DS_LOAD = 3'b011,
    DS_TAIL = 3'b100,
    DS_WAITCLK = 3'b101,
    DS_INIT = 3'b110,
    DS_USER = 3'b111
  } ppcp_dev_state_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_REQ = 3'b001,
    HS_WAIT = 3'b010,
    HS_WORD = 3'b011,
    HS_WAITCD = 3'b100,
    HS_FALLS = 3'b101,
    HS_DONE = 3'b110
  } ppcp_host_state_t;

endpackage

// File: design/ppcp_link_if.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Configuration link between host and device
interface ppcp_link_if;
  logic reconfigRequestN;
  logic cfgStatusN;
  logic loadComplete;
  logic cfgBitClock;
  logic [31:0] cfgData;
  logic startupDoneN;

  modport dev (
    input reconfigRequestN,
    input cfgBitClock,
    input cfgData,
    output cfgStatusN,
    output loadComplete,
    output startupDoneN
  );

  modport host (
    output reconfigRequestN,
    output cfgBitClock,
    output cfgData,
    input cfgStatusN,
    input loadComplete,
    input startupDoneN
  );
endinterface
`default_nettype wire

// File: design/ppcp_sync.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Two-flop synchroniser with edge detection per bit
module ppcp_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] prev;

  // First stage feeds only the second, edges come from later stages
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          meta[i] <= 1'b0;
          q[i] <= 1'b0;
          prev[i] <= 1'b0;
        end
        else
        begin
          meta[i] <= d[i];
          q[i] <= meta[i];
          prev[i] <= q[i];
        end
      end
      assign rise[i] = q[i] & ~prev[i];
      assign fall[i] = ~q[i] & prev[i];
    end
  endgenerate
endmodule
`default_nettype wire

// File: design/ppcp_device_end.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - User mode: all lines high; request low reconfigures
// - Status low throughout power-on delay
// - Load-complete low before and during loading
// - Host must send the whole image
// - Load-complete rises after the last word received
// - Host gives two falling edges afterwards
// - Bit clock ignored once configured
// - Host never floats bit clock afterwards
// - Narrow modes use low data bits only
// - Startup-done driven low once option loaded
// - Host may pause clock low, data first
// - Words captured on bit clock rising edges
// - Host holds request low 2 us minimum
// - Both outputs low within 600 ns
// - Status low 268 to 1506 us
// - Host waits after status or request rises
// - Host clock rate and duty limits
// - Internal oscillator init 175 to 437 us
// - User clock: wait, then 8576 cycles
// - Ratio set by width and features
// - Host stops clock only after ratio-1 cycles
module ppcp_device_end
  import ppcp_pkg::*;
#(
  parameter int unsigned POR_CYC = POR_DELAY_CYC,
  parameter int unsigned STATUS_MIN_CYC = STATUS_LOW_MIN_CYC,
  parameter int unsigned INIT_DELAY_CYC = INIT_CYC,
  parameter int unsigned USER_CLKS = USER_INIT_CLKS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  ppcp_link_if.dev link,
  input wire logic [1:0] busWidth,
  input wire logic [3:0] clocksPerWord,
  input wire logic [31:0] imageWords,
  input wire logic useStartupClock,
  input wire logic user_startup_clock,
  output logic userMode,
  output logic wordValid,
  output logic [31:0] wordData,
  output logic [31:0] wordsTaken
);
  // =====================================================================
  // Pin synchronisers
  logic [2:0] ctlQ;
  logic [2:0] ctlRise;
  logic [2:0] ctlFall;
  logic [31:0] dataQ;
  logic reqN;
  logic bitRise;
  logic bitFall;
  logic userClkRise;

  // Data passes the same two stages as the clock, so a rise sees settled data
  ppcp_sync #(.WIDTH(3)) u_ctl_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d({user_startup_clock, link.reconfigRequestN, link.cfgBitClock}),
    .q(ctlQ),
    .rise(ctlRise),
    .fall(ctlFall)
  );

  ppcp_sync #(.WIDTH(32)) u_data_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d(link.cfgData),
    .q(dataQ),
    .rise(),
    .fall()
  );

  assign reqN = ctlQ[1];
  assign bitRise = ctlRise[0];
  assign bitFall = ctlFall[0];
  assign userClkRise = ctlRise[2];

  // =====================================================================
  // Sequencer
  ppcp_dev_state_t state;
  ppcp_dev_state_t next_state;
  logic [CNT_W-1:0] cnt;
  logic [3:0] ratio;
  logic [3:0] phase;
  logic [1:0] widthSel;
  logic useUserClk;
  logic [31:0] maskedData;
  logic lastWord;

  // Narrow modes take the low lanes; upper lanes stay with user logic
  always_comb
  begin
    case (widthSel)
      WIDTH_8: maskedData = {24'h000000, dataQ[7:0]};
      WIDTH_16: maskedData = {16'h0000, dataQ[15:0]};
      default: maskedData = dataQ;
    endcase
  end

  assign lastWord = (wordsTaken + 32'h00000001) >= imageWords;

  // Next state; a low request overrides everything after power-on
  always_comb
  begin
    next_state = state;
    if (state != DS_POR && !reqN)
    begin
      next_state = DS_HOLD;
    end
    else
    begin
      case (state)
        DS_POR:
          if (cnt >= CNT_W'(POR_CYC - 1))
          begin
            next_state = DS_LOAD;
          end
        DS_HOLD:
          next_state = DS_STATUS;
        DS_STATUS:
          if (cnt >= CNT_W'(STATUS_MIN_CYC - 1))
          begin
            next_state = DS_LOAD;
          end
        DS_LOAD:
          if (bitRise && phase == 4'h0 && lastWord)
          begin
            next_state = DS_TAIL;
          end
        DS_TAIL:
          if (bitFall && cnt == CNT_W'(TAIL_FALLS - 1) + CNT_W'(ratio)) // Own group falls first
          begin
            next_state = useUserClk ? DS_WAITCLK : DS_INIT;
          end
        DS_WAITCLK:
          if (cnt >= CNT_W'(STARTUP_WAIT_CYC - 1))
          begin
            next_state = DS_INIT;
          end
        DS_INIT:
          if (useUserClk ? (userClkRise && cnt == CNT_W'(USER_CLKS - 1))
                         : (cnt >= CNT_W'(INIT_DELAY_CYC - 1)))
          begin
            next_state = DS_USER;
          end
        DS_USER:
          next_state = DS_USER;
        default:
          next_state = DS_POR;
      endcase
    end
  end

  // State and the shared interval counter
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= DS_POR;
      cnt <= '0;
    end
    else
    begin
      state <= next_state;
      if (next_state != state && !(state == DS_HOLD && next_state == DS_STATUS))
      begin
        cnt <= '0;
      end
      else if (state == DS_TAIL)
      begin
        cnt <= bitFall ? cnt + 1'b1 : cnt;
      end
      else if (state == DS_INIT && useUserClk)
      begin
        cnt <= userClkRise ? cnt + 1'b1 : cnt;
      end
      else if (cnt != {CNT_W{1'b1}})
      begin
        // Saturates so a very long request pulse cannot wrap the count
        cnt <= cnt + 1'b1;
      end
    end
  end

  // Straps are caught when loading begins, not under reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ratio <= 4'h1;
      widthSel <= WIDTH_8;
      useUserClk <= 1'b0;
    end
    else if (next_state == DS_LOAD && state != DS_LOAD)
    begin
      ratio <= (clocksPerWord == 4'h0) ? 4'h1 : clocksPerWord;
      widthSel <= busWidth;
      useUserClk <= useStartupClock;
    end
  end

  // Word capture: first rise of each group of ratio rises
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= 4'h0;
      wordValid <= 1'b0;
      wordData <= 32'h00000000;
      wordsTaken <= 32'h00000000;
    end
    else
    begin
      wordValid <= 1'b0;
      if (state != DS_LOAD)
      begin
        phase <= 4'h0;
        if (next_state == DS_LOAD)
        begin
          wordsTaken <= 32'h00000000;
        end
      end
      else if (bitRise)
      begin
        phase <= (phase == ratio - 4'h1) ? 4'h0 : phase + 4'h1;
        if (phase == 4'h0)
        begin
          wordValid <= 1'b1;
          wordData <= maskedData;
          wordsTaken <= wordsTaken + 32'h00000001;
        end
      end
    end
  end

  // =====================================================================
  // Link outputs, registered from the next state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.cfgStatusN <= 1'b0;
      link.loadComplete <= 1'b0;
      userMode <= 1'b0;
    end
    else
    begin
      // Status and load-complete drop one cycle after the synced request
      link.cfgStatusN <= !(next_state inside {DS_POR, DS_HOLD, DS_STATUS});
      link.loadComplete <= next_state inside {DS_TAIL, DS_WAITCLK, DS_INIT, DS_USER};
      userMode <= next_state == DS_USER;
    end
  end

  // Startup-done sits high until the option arrives in the image
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.startupDoneN <= 1'b1;
    end
    else if (next_state == DS_HOLD || next_state == DS_USER)
    begin
      link.startupDoneN <= 1'b1;
    end
    else if (state == DS_LOAD && bitRise && phase == 4'h0 && wordsTaken == 32'h00000000
             && maskedData[OPT_STARTUP_DONE_BIT])
    begin
      link.startupDoneN <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: design/ppcp_host_end.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Configuration host: APB registers in, configuration link out
module ppcp_host_end
  import ppcp_pkg::*;
#(
  parameter int unsigned HALF_CYC = HALF_PERIOD_CYC,
  parameter int unsigned WAIT_REQ_CYC = REQ_HIGH_TO_CLK_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ppcp_link_if.host link
);
  // =====================================================================
  // Return-line synchronisers
  logic [2:0] retQ;
  logic [2:0] retFall;
  logic statusHigh;
  logic doneHigh;

  ppcp_sync #(.WIDTH(3)) u_ret_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .d({link.startupDoneN, link.loadComplete, link.cfgStatusN}),
    .q(retQ),
    .rise(),
    .fall(retFall)
  );
  assign statusHigh = retQ[0];
  assign doneHigh = retQ[1];

  // =====================================================================
  // Registers and APB slave
  ppcp_host_state_t state;
  logic [31:0] ctrl;
  logic [31:0] imageLen;
  logic [31:0] dataReg;
  logic dataFull;
  logic startPulse;
  logic errFlag;
  logic [31:0] sent;
  logic [3:0] ratio;
  logic [3:0] pulses;
  logic [CNT_W-1:0] phaseCnt;
  logic [CNT_W-1:0] cnt;
  logic access;
  logic take;
  logic mapped;
  logic canAccept;
  logic loadWord;

  assign access = psel && penable;
  assign mapped = paddr inside {REG_CTRL, REG_LEN, REG_DATA, REG_STATUS};
  // A data write waits while the previous word is still unsent
  assign canAccept = !(paddr == REG_DATA && pwrite && dataFull);
  assign take = access && pready;
  assign ratio = (ctrl[CTRL_RATIO_LSB +: 4] == 4'h0) ? 4'h1 : ctrl[CTRL_RATIO_LSB +: 4];
  assign loadWord = state == HS_WORD && dataFull && pulses == 4'h0 && !link.cfgBitClock;

  // Ready is raised one cycle into the access phase and the write lands with it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= access && !pready && canAccept;
      pslverr <= access && !pready && canAccept && !mapped;
      if (access && !pready)
      begin
        case (paddr)
          REG_CTRL: prdata <= ctrl;
          REG_LEN: prdata <= imageLen;
          REG_STATUS: prdata <= {sent[15:0], 8'h00, 1'b0, (state == HS_DONE), errFlag,
                                 dataFull, retQ[2], doneHigh, statusHigh,
                                 (state != HS_IDLE)};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Control and length registers; start bit is a write pulse only
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= CTRL_RST;
      imageLen <= LEN_RST;
      startPulse <= 1'b0;
    end
    else
    begin
      startPulse <= take && pwrite && paddr == REG_CTRL && pwdata[CTRL_START_BIT];
      if (take && pwrite && paddr == REG_CTRL)
      begin
        ctrl <= {pwdata[31:1], 1'b0};
      end
      if (take && pwrite && paddr == REG_LEN)
      begin
        imageLen <= pwdata;
      end
    end
  end

  // One-word holding register between software and the link
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dataReg <= 32'h00000000;
      dataFull <= 1'b0;
    end
    else if (take && pwrite && paddr == REG_DATA)
    begin
      dataReg <= pwdata;
      dataFull <= 1'b1;
    end
    else if (loadWord || state == HS_IDLE)
    begin
      dataFull <= 1'b0;
    end
  end

  // =====================================================================
  // Bit clock divider; a burst of pulses always ends with the clock low
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link.cfgBitClock <= 1'b0;
      phaseCnt <= '0;
      pulses <= 4'h0;
    end
    else if (loadWord)
    begin
      pulses <= ratio;
      phaseCnt <= '0;
    end
    else if (state == HS_WAITCD && doneHigh)
    begin
      pulses <= 4'(TAIL_FALLS);
      phaseCnt <= '0;
    end
    else if (pulses != 4'h0)
    begin
      // Equal halves keep each phase well above 45 percent
      if (phaseCnt == CNT_W'(HALF_CYC - 1))
      begin
        phaseCnt <= '0;
        link.cfgBitClock <= !link.cfgBitClock;
        if (link.cfgBitClock)
        begin
          pulses <= pulses - 4'h1;
        end
      end
      else
      begin
        phaseCnt <= phaseCnt + 1'b1;
      end
    end
  end

  // =====================================================================
  // Load sequence
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= HS_IDLE;
      cnt <= '0;
      sent <= 32'h00000000;
      errFlag <= 1'b0;
      link.reconfigRequestN <= 1'b1;
      link.cfgData <= 32'h00000000;
    end
    else
    begin
      cnt <= cnt + 1'b1;
      case (state)
        HS_IDLE:
          if (startPulse)
          begin
            state <= HS_REQ;
            cnt <= '0;
            sent <= 32'h00000000;
            errFlag <= 1'b0;
            link.reconfigRequestN <= 1'b0;
          end
        HS_REQ:
          if (cnt >= CNT_W'(REQ_LOW_CYC - 1))
          begin
            state <= HS_WAIT;
            cnt <= '0;
            link.reconfigRequestN <= 1'b1;
          end
        HS_WAIT:
          if (ctrl[CTRL_MONITOR_BIT] && !statusHigh)
          begin
            cnt <= '0;
          end
          else if (cnt >= CNT_W'(ctrl[CTRL_MONITOR_BIT] ? STATUS_TO_CLK_CYC - 1
                                                        : WAIT_REQ_CYC - 1))
          begin
            state <= HS_WORD;
          end
        HS_WORD:
          if (retFall[0])
          begin
            state <= HS_IDLE;
            errFlag <= 1'b1;
          end
          else if (loadWord)
          begin
            // Data is placed while the clock is low, before its next rise
            link.cfgData <= dataReg;
            sent <= sent + 32'h00000001;
          end
          else if (pulses == 4'h0 && !link.cfgBitClock && sent >= imageLen)
          begin
            // The last group already ran ratio-1 cycles past its capture
            state <= HS_WAITCD;
          end
        HS_WAITCD:
          if (retFall[0])
          begin
            state <= HS_IDLE;
            errFlag <= 1'b1;
          end
          else if (doneHigh)
          begin
            state <= HS_FALLS;
          end
        HS_FALLS:
          if (pulses == 4'h0 && !link.cfgBitClock)
          begin
            state <= HS_DONE;
          end
        HS_DONE:
          if (startPulse)
          begin
            state <= HS_REQ;
            cnt <= '0;
            sent <= 32'h00000000;
            link.reconfigRequestN <= 1'b0;
          end
        default:
          state <= HS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: dv/ppcp_properties.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Link checker beside the interface joining both ends
module ppcp_properties
  import ppcp_pkg::*;
#(
  parameter int unsigned POR_CYC = 50,
  parameter int unsigned STATUS_MIN_CYC = 300,
  parameter int unsigned WAIT_REQ_CYC = 400
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reconfigRequestN,
  input wire logic cfgStatusN,
  input wire logic loadComplete,
  input wire logic cfgBitClock,
  input wire logic startupDoneN
);
  int unsigned tRst, tReqLo, tReqHi, tStHi;
  logic reqSeen, reqOld;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  function automatic int unsigned inc(input int unsigned x);
    return (x < 32'h000fffff) ? x + 1 : x;
  endfunction

  // Elapsed-time counters; they saturate so long idle spells never wrap
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {tRst, tReqLo, tReqHi, tStHi} <= '0;
      reqSeen <= 1'b0;
      reqOld <= 1'b1;
    end
    else
    begin
      tRst <= inc(tRst);
      tReqLo <= (reqOld && !reconfigRequestN) ? '0 : inc(tReqLo);
      tReqHi <= reconfigRequestN ? inc(tReqHi) : '0;
      tStHi <= cfgStatusN ? inc(tStHi) : '0;
      reqSeen <= reqSeen || !reconfigRequestN;
      reqOld <= reconfigRequestN;
    end
  end

  property p_req_drop;
    $fell(reconfigRequestN) |-> ##[1:60] (!cfgStatusN && !loadComplete);
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("outputs slow to fall");
  property p_req_width;
    $rose(reconfigRequestN) && reqSeen |-> tReqLo >= REQ_LOW_CYC - 1;
  endproperty
  a_req_width: assert property (p_req_width) else $error("request pulse too short");
  property p_status_min;
    $rose(cfgStatusN) && reqSeen |-> tReqLo >= STATUS_MIN_CYC;
  endproperty
  a_status_min: assert property (p_status_min) else $error("status low too short");
  property p_por;
    $rose(cfgStatusN) && !reqSeen |-> tRst >= POR_CYC - 1;
  endproperty
  a_por: assert property (p_por) else $error("status rose inside power-on delay");
  property p_lc_low;
    !cfgStatusN |=> !loadComplete;
  endproperty
  a_lc_low: assert property (p_lc_low) else $error("load complete high in hold");
  property p_lc_hold;
    loadComplete && reconfigRequestN |=> loadComplete;
  endproperty
  a_lc_hold: assert property (p_lc_hold) else $error("load complete dropped");
  property p_opt_low;
    $fell(startupDoneN) |-> cfgStatusN && !loadComplete;
  endproperty
  a_opt_low: assert property (p_opt_low) else $error("startup done fell off load");
  property p_tail;
    $rose(loadComplete) |-> ##[1:200] $fell(cfgBitClock) ##[1:100] $fell(cfgBitClock);
  endproperty
  a_tail: assert property (p_tail) else $error("trailing falls missing");
  property p_first_rise;
    $rose(cfgBitClock) |-> tStHi >= STATUS_TO_CLK_CYC || tReqHi >= WAIT_REQ_CYC;
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("bit clock too early");

  c_load: cover property ($rose(loadComplete));
  c_opt: cover property ($fell(startupDoneN));
  c_reconf: cover property ($fell(reconfigRequestN) && loadComplete);
endmodule
`default_nettype wire

// File: dv/ppcp_tb.sv
`timescale 1ns/1ns
`default_nettype none
// =====================================================================
// Bench: APB into the host end, device end seen at its user side
module ppcp_tb
  import ppcp_pkg::*;
;
  logic core_clk = 0;
  logic rst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd, wordData, mask, taken;
  logic [31:0] expW [4];
  logic [31:0] nWords = 32'h1;
  logic [1:0] busW = WIDTH_32;
  logic [3:0] cpw = 4'h1;
  logic useUsr = 0;
  logic usrClk = 0;
  logic pready, pslverr, userMode, wordValid, err;
  int mismatches = 0;
  int check_count = 0;
  int idx = 0;
  int t0;

  ppcp_link_if link();
  ppcp_host_end #(.WAIT_REQ_CYC(400)) i_ppcp_host_end (.core_clk(core_clk),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  ppcp_device_end #(.POR_CYC(50), .STATUS_MIN_CYC(300), .INIT_DELAY_CYC(100), .USER_CLKS(20))
    i_ppcp_device_end (.core_clk(core_clk), .rst_n(rst_n), .link(link), .busWidth(busW),
    .clocksPerWord(cpw), .imageWords(nWords), .useStartupClock(useUsr),
    .user_startup_clock(usrClk), .userMode(userMode), .wordValid(wordValid),
    .wordData(wordData), .wordsTaken(taken));
  ppcp_properties i_ppcp_properties (
    .core_clk(core_clk), .rst_n(rst_n), .reconfigRequestN(link.reconfigRequestN),
    .cfgStatusN(link.cfgStatusN), .loadComplete(link.loadComplete),
    .cfgBitClock(link.cfgBitClock), .startupDoneN(link.startupDoneN));

  // Core clock at 100 MHz; start-up clock free-running, 125 ns
  always #5 core_clk = ~core_clk;
  always
  begin
    #62 usrClk = ~usrClk;
    #63 usrClk = ~usrClk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Full load of n words; start-up timing bounds allow for sync delay
  task automatic run(input logic [1:0] w, input logic [3:0] r, input logic u,
    input logic mon, input logic [31:0] n, input logic opt);
    busW <= w;
    cpw <= r;
    useUsr <= u;
    nWords <= n;
    mask = (w == WIDTH_8) ? 32'hff : (w == WIDTH_16) ? 32'hffff : '1;
    for (int i = 0; i < 4; i++)
      expW[i] = 32'h9c6ae5b2 + i * 32'h01111112;
    expW[0][0] = opt;
    idx = 0;
    apb(1'b1, REG_LEN, n);
    apb(1'b1, REG_CTRL, {24'h0, r, 2'b0, mon, 1'b1});
    for (int i = 0; i < n; i++)
      apb(1'b1, REG_DATA, expW[i]);
    for (t0 = 0; t0 < 20000 && link.loadComplete !== 1'b1; t0++)
      @(posedge core_clk);
    // One more edge so the word monitor has counted the last word
    @(posedge core_clk);
    check(link.loadComplete, 1'b1);
    check(idx, n);
    check(taken, n);
    check(link.startupDoneN, !opt);
    for (t0 = 0; t0 < 5000 && userMode !== 1'b1; t0++)
      @(posedge core_clk);
    check(t0 >= (u ? 230 : 100) && t0 < (u ? 400 : 250), 1);
    check({link.reconfigRequestN, link.cfgStatusN, link.loadComplete}, 3'h7);
    apb(1'b0, REG_STATUS, '0);
    check(rd & 32'hffff0040, {n[15:0], 16'h0040});
  endtask

  // Each captured word is the host's word cut to the bus width
  always @(posedge core_clk)
    if (wordValid === 1'b1)
    begin
      check(wordData, expW[idx] & mask);
      idx++;
    end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // A hang ends the run as a failure
  initial
  begin
    #900000;
    mismatches++;
    finish_test();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    check({link.cfgStatusN, link.loadComplete}, 2'h0);
    apb(1'b0, REG_CTRL, '0);
    check(rd, CTRL_RST);
    apb(1'b0, REG_LEN, '0);
    check(rd, LEN_RST);
    apb(1'b1, 8'h10, 32'h5);
    check(err, 1'b1);
    apb(1'b0, 8'h10, '0);
    check(rd, '0);
    repeat (60) @(posedge core_clk);
    run(WIDTH_32, 4'h1, 1'b0, 1'b1, 32'h3, 1'b1);
    run(WIDTH_8, 4'h2, 1'b1, 1'b0, 32'h4, 1'b0);
    run(WIDTH_16, 4'h4, 1'b0, 1'b1, 32'h2, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
